// ---- ivp_pkg.sv ----
// constants for the interrupt vector and priority map: source table, levels, widths.
// assumes sources are listed in ascending vector order; index order is the fixed rank.
package ivp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 18;
  localparam int NUM_MOD = 9;
  localparam int SRC_W = 5;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 16;
  localparam int LVL_W = 4;
  localparam int FLD_W = 3;
  localparam int MOD_W = 4;

  // ----------------------------------------------------------------
  // fixed levels and address shift
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] NMI_LEVEL = 4'h8;
  localparam int VEC_ADDR_SHIFT = 2;
  localparam logic [VEC_W-1:0] VEC_POWER_ON = 8'h00;
  localparam logic [VEC_W-1:0] VEC_LAST = 8'h27;

  // ----------------------------------------------------------------
  // source indices (ascending vector order)
  // ----------------------------------------------------------------
  localparam int SRC_NMI = 0;
  localparam int SRC_IRQ0 = 1;
  localparam int SRC_SWEND = 9;
  localparam int SRC_WDT = 10;
  localparam int SRC_ADC = 11;
  localparam int SRC_TMR_A = 12;
  localparam int SRC_TMR_OVF = 16;
  localparam int SRC_SPARE = 17;

  // vector number of each source; index 17 is an unused spare slot held off
  localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
    8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
    8'h18, 8'h19, 8'h1C, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h00};

  // module priority field that governs each source; NMI uses none
  localparam logic [MOD_W-1:0] SRC_MOD [NUM_SRC] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4,
    4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0};

  // sources that may start the transfer controller (bit n = source n)
  localparam logic [NUM_SRC-1:0] SRC_XFER_OK = 18'h0FBFE;

  // sources that actually exist (spare held off)
  localparam logic [NUM_SRC-1:0] SRC_PRESENT = 18'h1FFFF;

endpackage

// ---- ivp_rank.sv ----
// fixed-order arbiter: highest level wins, ties go to the lowest index.
// assumes index order equals ascending vector number.
`timescale 1ns/1ps
`default_nettype none
module ivp_rank (
  input wire logic [ivp_pkg::NUM_SRC-1:0] valid,
  input wire logic [ivp_pkg::LVL_W-1:0] level [ivp_pkg::NUM_SRC],
  output logic found,
  output logic [ivp_pkg::SRC_W-1:0] win_idx,
  output logic [ivp_pkg::LVL_W-1:0] win_level
);
  import ivp_pkg::*;

  // ----------------------------------------------------------------
  // scan from the highest vector down so a lower vector of equal level
  // overwrites; the non-strict >= compare keeps the ranking fixed in hardware
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    win_idx = '0;
    win_level = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (valid[i] && (!found || level[i] >= win_level)) begin
        found = 1'b1;
        win_idx = SRC_W'(i);
        win_level = level[i];
      end
    end
  end

endmodule
`default_nettype wire

// ---- ivp_map.sv ----
// vector assignment and priority resolution for the interrupt controller.
// assumes request lines are already edge/level qualified and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - equal level: the smallest vector number wins first
// - per-module software priority field; higher value outranks lower
// - equal levels and sources within one module use fixed hardware order
// - qualifying requests can start the transfer controller instead of the cpu
// - vector address is four times the vector number, 0 through 39
// - conversion done uses vector 28 and may start a transfer
// - timer0 compare a-d use vectors 32-35, overflow 36; only compares start transfers
// - reserved system slots 2-4, 6, 12-15 never carry a request
// - nonmaskable pin request uses vector 7 regardless of priority fields
// - external pin requests 0-7 use vectors 16-23 in order
// - nonmaskable request has fixed level 8 and is always accepted
module ivp_map (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic nmi_request,
  input wire logic [7:0] ext_irq_request,
  input wire logic software_transfer_end_request,
  input wire logic watchdog_interval_request,
  input wire logic conversion_done_request,
  input wire logic [3:0] timer0_capture_compare_request,
  input wire logic timer0_overflow_request,
  input wire logic [ivp_pkg::NUM_SRC-1:0] source_enable,
  input wire logic [ivp_pkg::NUM_SRC-1:0] transfer_select,
  input wire logic [ivp_pkg::FLD_W-1:0] module_priority_level_regs [ivp_pkg::NUM_MOD],
  output logic cpu_request,
  output logic [ivp_pkg::VEC_W-1:0] cpu_vector,
  output logic [ivp_pkg::ADDR_W-1:0] cpu_vector_addr,
  output logic [ivp_pkg::LVL_W-1:0] cpu_level,
  output logic transfer_controller_start,
  output logic [ivp_pkg::VEC_W-1:0] transfer_controller_vector
);
  import ivp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] vec_to_addr(input logic [VEC_W-1:0] v);
    vec_to_addr = ADDR_W'({v, 2'b00});
  endfunction

  // system slots are never handed out; the source table holds none of them
  function automatic logic is_system_slot(input logic [VEC_W-1:0] v);
    is_system_slot = (v >= 8'h02 && v <= 8'h04) || v == 8'h06 ||
                     (v >= 8'h0C && v <= 8'h0F);
  endfunction

  // ----------------------------------------------------------------
  // raw request vector in source-table order
  // ----------------------------------------------------------------
  wire logic [NUM_SRC-1:0] raw_req;
  assign raw_req = {1'b0,                               // spare slot
                    timer0_overflow_request,            // vector 36
                    timer0_capture_compare_request,     // vectors 35..32
                    conversion_done_request,            // vector 28
                    watchdog_interval_request,          // vector 25
                    software_transfer_end_request,      // vector 24
                    ext_irq_request,                    // vectors 23..16
                    nmi_request};                       // vector 7

  // ----------------------------------------------------------------
  // qualification and effective levels
  // ----------------------------------------------------------------
  wire logic [NUM_SRC-1:0] valid;
  logic [LVL_W-1:0] eff_level [NUM_SRC];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g == SRC_NMI) begin : g_nmi
        // enable ignored: the nonmaskable request is always accepted
        assign valid[g] = raw_req[g];
        assign eff_level[g] = NMI_LEVEL;
      end else begin : g_mod
        assign valid[g] = raw_req[g] && source_enable[g] && SRC_PRESENT[g] &&
                          !is_system_slot(SRC_VEC[g]);
        assign eff_level[g] = {1'b0, module_priority_level_regs[SRC_MOD[g]]};
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic found;
  logic [SRC_W-1:0] win_idx;
  logic [LVL_W-1:0] win_level;

  ivp_rank u_rank (
    .valid(valid),
    .level(eff_level),
    .found(found),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  wire logic [VEC_W-1:0] win_vec;
  wire logic win_to_xfer;
  assign win_vec = SRC_VEC[win_idx];
  // a qualifying winner with its transfer select set goes to the transfer
  // controller only; nmi, watchdog and timer overflow can never go there
  assign win_to_xfer = found && SRC_XFER_OK[win_idx] && transfer_select[win_idx];

  // ----------------------------------------------------------------
  // registered outputs, one cycle after the requests
  // ----------------------------------------------------------------
  logic cpu_req_r;
  logic [VEC_W-1:0] cpu_vec_r;
  logic [ADDR_W-1:0] cpu_addr_r;
  logic [LVL_W-1:0] cpu_lvl_r;
  logic xfer_req_r;
  logic [VEC_W-1:0] xfer_vec_r;

  wire logic cpu_req_nxt;
  assign cpu_req_nxt = found && !win_to_xfer;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpu_req_r <= 1'b0;
      cpu_vec_r <= VEC_POWER_ON;
      cpu_addr_r <= '0;
      cpu_lvl_r <= '0;
      xfer_req_r <= 1'b0;
      xfer_vec_r <= VEC_POWER_ON;
    end else begin
      cpu_req_r <= cpu_req_nxt;
      cpu_vec_r <= cpu_req_nxt ? win_vec : VEC_POWER_ON;
      cpu_addr_r <= cpu_req_nxt ? vec_to_addr(win_vec) : '0;
      cpu_lvl_r <= cpu_req_nxt ? win_level : '0;
      xfer_req_r <= win_to_xfer;
      xfer_vec_r <= win_to_xfer ? win_vec : VEC_POWER_ON;
    end
  end

  assign cpu_request = cpu_req_r;
  assign cpu_vector = cpu_vec_r;
  assign cpu_vector_addr = cpu_addr_r;
  assign cpu_level = cpu_lvl_r;
  assign transfer_controller_start = xfer_req_r;
  assign transfer_controller_vector = xfer_vec_r;

endmodule
`default_nettype wire

// ---- ivp_src_model.sv ----
// far-side request sources: one pattern bit per request line.
// assumes the bench changes the pattern away from the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ivp_src_model (
  input wire logic [16:0] pat,
  output logic nmi_request,
  output logic [7:0] ext_irq_request,
  output logic software_transfer_end_request,
  output logic watchdog_interval_request,
  output logic conversion_done_request,
  output logic [3:0] timer0_capture_compare_request,
  output logic timer0_overflow_request
);
  // level requests, held as long as the source pends
  assign {timer0_overflow_request, timer0_capture_compare_request, conversion_done_request,
    watchdog_interval_request, software_transfer_end_request, ext_irq_request,
    nmi_request} = pat;
endmodule
`default_nettype wire

// ---- ivp_map_asserts.sv ----
// output checks for the vector and priority map.
// assumes binding onto ivp_map; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ivp_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic nmi_request,
  input wire logic cpu_request,
  input wire logic [ivp_pkg::VEC_W-1:0] cpu_vector,
  input wire logic [ivp_pkg::ADDR_W-1:0] cpu_vector_addr,
  input wire logic [ivp_pkg::LVL_W-1:0] cpu_level,
  input wire logic transfer_controller_start,
  input wire logic [ivp_pkg::VEC_W-1:0] transfer_controller_vector
);
  import ivp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_nmi_in;
    nmi_request;
  endsequence
  sequence s_nmi_out;
    cpu_request && cpu_vector == 8'h07 && cpu_level == 4'h8;
  endsequence
  AST_NMI: assert property (s_nmi_in |=> s_nmi_out)
    else $error("nmi not delivered on vector 7");
  AST_NMI_CPU: assert property (s_nmi_in |=> !transfer_controller_start)
    else $error("nmi routed away from cpu");
  AST_ADDR: assert property (cpu_request |-> cpu_vector_addr == {6'h00, cpu_vector, 2'h0})
    else $error("vector address not four times vector");
  AST_RANGE: assert property (cpu_request |-> cpu_vector <= 8'h27)
    else $error("vector beyond last slot");
  AST_RSV: assert property (cpu_request |-> !(cpu_vector inside {[2:4], 6, [12:15]}))
    else $error("reserved slot delivered");
  AST_LVL: assert property (cpu_request |-> (cpu_vector == 8'h07) == (cpu_level == 4'h8))
    else $error("level 8 not tied to vector 7");
  AST_ONE: assert property (!(cpu_request && transfer_controller_start))
    else $error("winner sent to both cpu and transfer unit");
  AST_XVEC: assert property (transfer_controller_start |->
    transfer_controller_vector inside {[16:24], 28, [32:35]})
    else $error("ineligible source started a transfer");
  AST_IDLE: assert property (!cpu_request |-> cpu_vector == 8'h00 && cpu_level == 4'h0)
    else $error("idle cpu outputs not cleared");
  AST_XIDLE: assert property (!transfer_controller_start |->
    transfer_controller_vector == 8'h00)
    else $error("idle transfer vector not cleared");
endmodule
`default_nettype wire
bind ivp_map ivp_chk u_ivp_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .nmi_request(nmi_request),
  .cpu_request(cpu_request),
  .cpu_vector(cpu_vector),
  .cpu_vector_addr(cpu_vector_addr),
  .cpu_level(cpu_level),
  .transfer_controller_start(transfer_controller_start),
  .transfer_controller_vector(transfer_controller_vector)
);

// ---- ivp_map_tb.sv ----
// self-checking bench for ivp_map with an integer arbitration model.
// assumes ivp_pkg is compiled first; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ivp_map_tb_top;
  import ivp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [16:0] pat = '0;
  logic [NUM_SRC-1:0] en = '0;
  logic [NUM_SRC-1:0] xs = '0;
  logic [FLD_W-1:0] fld [NUM_MOD];
  logic nmi_request, software_transfer_end_request, watchdog_interval_request;
  logic conversion_done_request, timer0_overflow_request, cpu_request;
  logic transfer_controller_start;
  logic [7:0] ext_irq_request;
  logic [3:0] timer0_capture_compare_request;
  logic [VEC_W-1:0] cpu_vector, transfer_controller_vector;
  logic [ADDR_W-1:0] cpu_vector_addr;
  logic [LVL_W-1:0] cpu_level;
  int miscompares = 0;
  int compares = 0;
  int bi = -1;
  int bl = -1;
  logic [31:0] s = 32'hDAAC;
  ivp_src_model u_ivp_src_model (
    .pat(pat),
    .nmi_request(nmi_request),
    .ext_irq_request(ext_irq_request),
    .software_transfer_end_request(software_transfer_end_request),
    .watchdog_interval_request(watchdog_interval_request),
    .conversion_done_request(conversion_done_request),
    .timer0_capture_compare_request(timer0_capture_compare_request),
    .timer0_overflow_request(timer0_overflow_request)
  );
  ivp_map u_ivp_map (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .nmi_request(nmi_request),
    .ext_irq_request(ext_irq_request),
    .software_transfer_end_request(software_transfer_end_request),
    .watchdog_interval_request(watchdog_interval_request),
    .conversion_done_request(conversion_done_request),
    .timer0_capture_compare_request(timer0_capture_compare_request),
    .timer0_overflow_request(timer0_overflow_request),
    .source_enable(en),
    .transfer_select(xs),
    .module_priority_level_regs(fld),
    .cpu_request(cpu_request),
    .cpu_vector(cpu_vector),
    .cpu_vector_addr(cpu_vector_addr),
    .cpu_level(cpu_level),
    .transfer_controller_start(transfer_controller_start),
    .transfer_controller_vector(transfer_controller_vector)
  );
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic int vec_of(int i);
    return i == 0 ? 7 : i <= 8 ? 15 + i : i == 9 ? 24 : i == 10 ? 25 : i == 11 ? 28 : 20 + i;
  endfunction
  function automatic int mod_of(int i);
    return i <= 2 ? i - 1 : i <= 8 ? (i + 1) / 2 : i <= 11 ? i - 4 : 8;
  endfunction
  function automatic logic [31:0] lf(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic model();
    int lv;
    bi = -1;
    bl = -1;
    for (int i = 0; i < 17; i++) begin
      lv = i == 0 ? 8 : int'(fld[mod_of(i)]);
      if (pat[i] && (i == 0 || en[i]) && lv > bl) begin
        bl = lv;
        bi = i;
      end
    end
  endtask
  task automatic check();
    bit tc;
    int v;
    // wdt (10), overflow (16) and nmi never start a transfer
    tc = bi >= 0 && xs[bi] && ((bi >= 1 && bi <= 9) || (bi >= 11 && bi <= 15));
    v = bi < 0 ? 0 : vec_of(bi);
    chk("cpu_request", 16'(cpu_request), 16'(bi >= 0 && !tc));
    chk("xfer_start", 16'(transfer_controller_start), 16'(tc));
    chk("xfer_vector", 16'(transfer_controller_vector), tc ? 16'(v) : 16'h0000);
    // a transfer-routed winner leaves the cpu side cleared
    chk("cpu_vector", 16'(cpu_vector), tc ? 16'h0000 : 16'(v));
    chk("cpu_vector_addr", cpu_vector_addr, tc ? 16'h0000 : 16'(v * 4));
    chk("cpu_level", 16'(cpu_level), 16'((bi < 0 || tc) ? 0 : bl));
  endtask
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    for (int m = 0; m < NUM_MOD; m++) fld[m] = 3'h0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int n = 0; n < 700; n++) begin
      @(negedge sys_clk);
      check();
      s = lf(s);
      // first each source alone, to cpu then to transfer; then random, ties early
      if (n < 34) begin
        pat = 17'h00001 << (n % 17);
        en = '1;
        xs = n < 17 ? '0 : '1;
      end else begin
        pat = s[16:0] & s[31:15];
        en = {s[5:0], s[31:20]};
        xs = {s[13:0], s[31:28]};
      end
      for (int m = 0; m < NUM_MOD; m++) fld[m] = n < 200 ? 3'(n) : 3'(s >> (3 * m));
      model();
      // a short reset mid-run must clear every output despite pending requests
      sys_rst = (n == 400 || n == 401);
      if (sys_rst) begin
        bi = -1;
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
